/* inc/pll_ctrl_pkg.sv */
// constants, register map and carrier types of the pll status / output driver block
// assumes an axi4-lite master of 32-bit data; byte address = 4 * register index
package pll_ctrl_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_OUT = 3;
    localparam int SYNC_STAGES = 2;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h1f;
    localparam logic [7:0] IDX_MON_EN = 8'h1a;
    localparam logic [7:0] IDX_PWR_DOWN = 8'h1c;
    localparam logic [7:0] IDX_OUTPUT_DRIVER_0 = 8'hf0;
    localparam logic [7:0] IDX_OUTPUT_DRIVER_1 = 8'hf1;
    localparam logic [7:0] IDX_OUTPUT_DRIVER_2 = 8'hf2;

    // status byte fields
    localparam int BIT_REF_SEL = 4;
    localparam int BIT_FB_PRESENT = 3;
    localparam int BIT_REF_INPUT_B_PRESENT = 2;
    localparam int BIT_REF_INPUT_A_PRESENT = 1;
    localparam int BIT_LOCK = 0;

    // monitor enable fields
    localparam int BIT_FB_MON_EN = 7;
    localparam int BIT_REF_INPUT_A_MON_EN = 6;
    localparam int BIT_REF_INPUT_B_MON_EN = 5;

    // power-down fields
    localparam int BIT_REF_INPUT_B_MON_OFF = 5;
    localparam int BIT_REF_INPUT_A_MON_OFF = 4;

    // output control fields
    localparam int BIT_PAIR_PD = 4;
    localparam int BIT_SWING_LSB = 1;
    localparam int BIT_DRV_PD = 0;

    // values after reset
    localparam logic [7:0] OUT_CTRL_RST = 8'h04;
    localparam logic [7:0] MON_EN_RST = 8'h00;
    localparam logic [7:0] PWR_DOWN_RST = 8'h22;

    // writable bits: the pair power-down exists on outputs 0 and 2 only
    localparam logic [7:0] OUT_PAIR_MASK = 8'h17;
    localparam logic [7:0] OUT_SOLO_MASK = 8'h07;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [6:0] {
        SEL_NONE = 7'h01,
        SEL_STATUS = 7'h02,
        SEL_MON = 7'h04,
        SEL_PD = 7'h08,
        SEL_OUTPUT_DRIVER_0 = 7'h10,
        SEL_OUTPUT_DRIVER_1 = 7'h20,
        SEL_OUTPUT_DRIVER_2 = 7'h40
    } reg_sel_t;

    localparam reg_sel_t OUT_SEL [NUM_OUT] = '{SEL_OUTPUT_DRIVER_0, SEL_OUTPUT_DRIVER_1, SEL_OUTPUT_DRIVER_2};

    // raw indications from the analog pll, asynchronous to aclk
    typedef struct packed {
        logic ref_b_selected;
        logic fb_clk_present;
        logic ref_b_present;
        logic ref_a_present;
        logic locked;
    } pll_pins_t;

    typedef struct packed {
        logic pair_pd_01;
        logic pair_pd_23;
        logic [NUM_OUT-1:0] driver_pd;
        logic [NUM_OUT-1:0][1:0] swing;
    } driver_ctrl_t;

    typedef struct packed {
        logic fb_mon_en;
        logic ref_a_mon_en;
        logic ref_b_mon_en;
        logic ref_a_mon_clk_off;
        logic ref_b_mon_clk_off;
        logic auto_switch_en;
    } monitor_ctrl_t;

endpackage : pll_ctrl_pkg

/* testbench/pll_status_and_output_driver_ctrl_bench.sv */
// self-checking bench for the pll status / output driver register bank
// assumes an axi4-lite slave; each handshake is awaited, only the watchdog ends a wait
`timescale 1ns/100ps
module pll_status_and_output_driver_ctrl_bench import pll_ctrl_pkg::*;;
    logic aclk;
    logic aresetn;
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic awready;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    pll_pins_t pll_pins;
    driver_ctrl_t driver_ctrl;
    monitor_ctrl_t monitor_ctrl;
    int num_errors;
    int comparisons;

    pll_status_and_output_driver_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pll_pins(pll_pins),
        .driver_ctrl(driver_ctrl), .monitor_ctrl(monitor_ctrl));

    always #50 aclk = ~aclk;

    task automatic end_of_test;
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // every bus task starts one edge later so no signal is assigned twice in a time step
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] data,
            input logic [3:0] strb, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, data};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        resp = 2'h3;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        // the answer may only follow once both address and data were taken
        chk("write handshake", 32'h0, {30'h0, awvalid, wvalid});
    endtask : axi_write

    task automatic axi_read(input logic [7:0] idx, output logic [31:0] data,
            output logic [1:0] resp);
        @(posedge aclk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        data = 32'hffffffff;
        resp = 2'h3;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        chk("read handshake", 32'h0, {31'h0, arvalid});
    endtask : axi_read

    task automatic wr_chk(input string name, input logic [7:0] idx, input logic [7:0] data,
            input logic [3:0] strb, input logic [1:0] er);
        logic [1:0] r;
        axi_write(idx, data, strb, r);
        chk({name, " bresp"}, {30'h0, er}, {30'h0, r});
    endtask : wr_chk

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp,
            input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        chk({name, " rdata"}, {24'h0, exp}, d);
        chk({name, " rresp"}, {30'h0, er}, {30'h0, r});
    endtask : rd_chk

    task automatic test_reset_values;
        chk("driver_ctrl reset", 32'h02a, {21'h0, driver_ctrl});
        chk("monitor_ctrl reset", 32'h02, {26'h0, monitor_ctrl});
        rd_chk("output_driver_0 reset", IDX_OUTPUT_DRIVER_0, 8'h04, RESP_OKAY);
        rd_chk("output_driver_1 reset", IDX_OUTPUT_DRIVER_1, 8'h04, RESP_OKAY);
        rd_chk("output_driver_2 reset", IDX_OUTPUT_DRIVER_2, 8'h04, RESP_OKAY);
        rd_chk("mon_en reset", IDX_MON_EN, 8'h00, RESP_OKAY);
        rd_chk("pwr_down reset", IDX_PWR_DOWN, 8'h22, RESP_OKAY);
    endtask : test_reset_values

    task automatic test_output_ctrl;
        wr_chk("output_driver_0 all", IDX_OUTPUT_DRIVER_0, 8'hff, 4'h1, RESP_OKAY);
        wr_chk("output_driver_1 all", IDX_OUTPUT_DRIVER_1, 8'hff, 4'h1, RESP_OKAY);
        wr_chk("output_driver_2 pair", IDX_OUTPUT_DRIVER_2, 8'h13, 4'h1, RESP_OKAY);
        rd_chk("output_driver_0 all", IDX_OUTPUT_DRIVER_0, 8'h17, RESP_OKAY);
        rd_chk("output_driver_1 reserved", IDX_OUTPUT_DRIVER_1, 8'h07, RESP_OKAY);
        rd_chk("output_driver_2 pair", IDX_OUTPUT_DRIVER_2, 8'h13, RESP_OKAY);
        chk("driver_ctrl set", 32'h7df, {21'h0, driver_ctrl});
        // a cleared lane strobe must leave the register alone
        wr_chk("output_driver_2 no strobe", IDX_OUTPUT_DRIVER_2, 8'h00, 4'he, RESP_OKAY);
        rd_chk("output_driver_2 no strobe", IDX_OUTPUT_DRIVER_2, 8'h13, RESP_OKAY);
    endtask : test_output_ctrl

    task automatic test_swing_codes;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr_chk("output_driver_0 swing", IDX_OUTPUT_DRIVER_0, {5'h0, c, 1'b0}, 4'h1, RESP_OKAY);
            rd_chk("output_driver_0 swing", IDX_OUTPUT_DRIVER_0, {5'h0, c, 1'b0}, RESP_OKAY);
            chk("swing0", {30'h0, c}, {30'h0, driver_ctrl.swing[0]});
            chk("pd0 off", 32'h0, {30'h0, driver_ctrl.pair_pd_01, driver_ctrl.driver_pd[0]});
        end
    endtask : test_swing_codes

    task automatic test_monitor_gates;
        logic [7:0] pd [3] = '{8'h10, 8'h00, 8'h20};
        logic [5:0] exp [3] = '{6'h04, 6'h01, 6'h02};
        for (int i = 0; i < 3; i++) begin
            wr_chk("pwr_down", IDX_PWR_DOWN, pd[i], 4'h1, RESP_OKAY);
            rd_chk("pwr_down", IDX_PWR_DOWN, pd[i], RESP_OKAY);
            chk("monitor_ctrl gates", {26'h0, exp[i]}, {26'h0, monitor_ctrl});
        end
    endtask : test_monitor_gates

    task automatic test_status;
        logic [7:0] mon [6] = '{8'h00, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20};
        logic [7:0] pd [6] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h20, 8'h00};
        logic [7:0] exp [6] = '{8'h11, 8'h19, 8'h11, 8'h13, 8'h11, 8'h15};
        wr_chk("mon_en all", IDX_MON_EN, 8'he0, 4'h1, RESP_OKAY);
        wr_chk("gates open", IDX_PWR_DOWN, 8'h00, 4'h1, RESP_OKAY);
        chk("monitor_ctrl on", 32'h39, {26'h0, monitor_ctrl});
        for (int p = 0; p < 32; p++) begin
            pll_pins <= p[4:0];
            repeat (3) @(posedge aclk);
            rd_chk("status pins", IDX_STATUS, {3'h0, p[4:0]}, RESP_OKAY);
        end
        // invalid presence flags read as absent while the lock and selection still show
        for (int i = 0; i < 6; i++) begin
            wr_chk("mon_en", IDX_MON_EN, mon[i], 4'h1, RESP_OKAY);
            wr_chk("gate", IDX_PWR_DOWN, pd[i], 4'h1, RESP_OKAY);
            rd_chk("status gated", IDX_STATUS, exp[i], RESP_OKAY);
        end
    endtask : test_status

    task automatic test_refusals;
        wr_chk("status write", IDX_STATUS, 8'h00, 4'h1, RESP_SLVERR);
        rd_chk("status kept", IDX_STATUS, 8'h15, RESP_OKAY);
        wr_chk("unmapped write", 8'h01, 8'hff, 4'h1, RESP_SLVERR);
        rd_chk("unmapped read", 8'h01, 8'h00, RESP_SLVERR);
        rd_chk("beyond output_driver_2", 8'hf3, 8'h00, RESP_SLVERR);
    endtask : test_refusals

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        pll_pins = '0;
        num_errors = 0;
        comparisons = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset_values();
        test_output_ctrl();
        test_swing_codes();
        test_monitor_gates();
        test_status();
        test_refusals();
        end_of_test();
    end

    // the full run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        end_of_test();
    end
endmodule : pll_status_and_output_driver_ctrl_bench

/* verilog/level_sync.sv */
// two-flop synchroniser for a group of independent level signals
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/100ps
module level_sync
    import pll_ctrl_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [SYNC_STAGES-1:0] stage;
            // first stage feeds only the second
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stage <= '0;
                end else begin
                    stage <= {stage[SYNC_STAGES-2:0], d[i]};
                end
            end
            assign q[i] = stage[SYNC_STAGES-1];
        end
    endgenerate

endmodule : level_sync

/* verilog/pll_status_and_output_driver_ctrl.sv */
// register bank: pll status readback and output driver control over axi4-lite
// assumes pll indications arrive asynchronously; one write and one read in flight
`timescale 1ns/100ps
module pll_status_and_output_driver_ctrl
    import pll_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pll_pins_t pll_pins,
    output driver_ctrl_t driver_ctrl,
    output monitor_ctrl_t monitor_ctrl
);

    // address decode shared by the read and write paths
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[ADDR_W-1:10] != '0) begin
            return SEL_NONE;
        end
        case (idx)
            IDX_STATUS: return SEL_STATUS;
            IDX_MON_EN: return SEL_MON;
            IDX_PWR_DOWN: return SEL_PD;
            IDX_OUTPUT_DRIVER_0: return SEL_OUTPUT_DRIVER_0;
            IDX_OUTPUT_DRIVER_1: return SEL_OUTPUT_DRIVER_1;
            IDX_OUTPUT_DRIVER_2: return SEL_OUTPUT_DRIVER_2;
            default: return SEL_NONE;
        endcase
    endfunction : decode

    // pll indications cross into aclk
    pll_pins_t pins_sync;

    level_sync #(
        .WIDTH($bits(pll_pins_t))
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pll_pins),
        .q(pins_sync)
    );

    logic [7:0] mon_en;
    logic [7:0] pwr_down;
    logic [7:0] out_ctrl [NUM_OUT];
    logic [7:0] stat_byte;
    logic fb_valid;
    logic ref_input_b_valid;
    logic ref_input_a_valid;

    // write channel state
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [ADDR_W-1:0] cur_awaddr;
    logic [7:0] cur_byte;
    logic cur_lane;
    reg_sel_t wr_sel;
    logic wr_ok;

    // read channel state
    logic ar_take;
    reg_sel_t rd_sel;
    logic [7:0] rd_byte;

    // flags are masked to zero while their monitor is not running, so a stale
    // presence never reads back as valid
    assign fb_valid = mon_en[BIT_FB_MON_EN];
    assign ref_input_b_valid = mon_en[BIT_REF_INPUT_B_MON_EN] && !pwr_down[BIT_REF_INPUT_B_MON_OFF];
    assign ref_input_a_valid = mon_en[BIT_REF_INPUT_A_MON_EN] && !pwr_down[BIT_REF_INPUT_A_MON_OFF];

    always_comb begin
        stat_byte = 8'h00;
        stat_byte[BIT_REF_SEL] = pins_sync.ref_b_selected;
        stat_byte[BIT_FB_PRESENT] = fb_valid && pins_sync.fb_clk_present;
        stat_byte[BIT_REF_INPUT_B_PRESENT] = ref_input_b_valid && pins_sync.ref_b_present;
        stat_byte[BIT_REF_INPUT_A_PRESENT] = ref_input_a_valid && pins_sync.ref_a_present;
        stat_byte[BIT_LOCK] = pins_sync.locked;
    end

    // write path: address and data taken in either order, answer once both held
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign cur_awaddr = aw_held ? aw_addr : awaddr;
    assign cur_byte = w_held ? w_byte : wdata[7:0];
    assign cur_lane = w_held ? w_lane : wstrb[0];
    assign wr_fire = (aw_held || aw_take) && (w_held || w_take);
    assign wr_sel = decode(cur_awaddr);
    assign wr_ok = (wr_sel != SEL_NONE) && (wr_sel != SEL_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
        end
    end

    // writes to the read-only status or an unmapped word change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_en <= MON_EN_RST;
        end else if (wr_fire && cur_lane && wr_sel == SEL_MON) begin
            mon_en <= cur_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_down <= PWR_DOWN_RST;
        end else if (wr_fire && cur_lane && wr_sel == SEL_PD) begin
            pwr_down <= cur_byte;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_OUT; i++) begin : g_out
            localparam logic [7:0] MASK = (i == 1) ? OUT_SOLO_MASK : OUT_PAIR_MASK;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    out_ctrl[i] <= OUT_CTRL_RST;
                end else if (wr_fire && cur_lane && wr_sel == OUT_SEL[i]) begin
                    out_ctrl[i] <= cur_byte & MASK;
                end
            end
            assign driver_ctrl.driver_pd[i] = out_ctrl[i][BIT_DRV_PD];
            assign driver_ctrl.swing[i] = out_ctrl[i][BIT_SWING_LSB +: 2];
        end
    endgenerate

    assign driver_ctrl.pair_pd_01 = out_ctrl[0][BIT_PAIR_PD];
    assign driver_ctrl.pair_pd_23 = out_ctrl[2][BIT_PAIR_PD];

    // switchover needs both monitor clocks running
    assign monitor_ctrl.fb_mon_en = mon_en[BIT_FB_MON_EN];
    assign monitor_ctrl.ref_a_mon_en = mon_en[BIT_REF_INPUT_A_MON_EN];
    assign monitor_ctrl.ref_b_mon_en = mon_en[BIT_REF_INPUT_B_MON_EN];
    assign monitor_ctrl.ref_a_mon_clk_off = pwr_down[BIT_REF_INPUT_A_MON_OFF];
    assign monitor_ctrl.ref_b_mon_clk_off = pwr_down[BIT_REF_INPUT_B_MON_OFF];
    assign monitor_ctrl.auto_switch_en =
        !pwr_down[BIT_REF_INPUT_A_MON_OFF] && !pwr_down[BIT_REF_INPUT_B_MON_OFF];

    // read path: one read in flight, data registered one cycle after the address
    assign arready = !rvalid;
    assign ar_take = arvalid && arready;
    assign rd_sel = decode(araddr);

    always_comb begin
        case (rd_sel)
            SEL_STATUS: rd_byte = stat_byte;
            SEL_MON: rd_byte = mon_en;
            SEL_PD: rd_byte = pwr_down;
            SEL_OUTPUT_DRIVER_0: rd_byte = out_ctrl[0];
            SEL_OUTPUT_DRIVER_1: rd_byte = out_ctrl[1];
            SEL_OUTPUT_DRIVER_2: rd_byte = out_ctrl[2];
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking

    default disable iff (!aresetn);

    sel_ref_read_a: assert property (
        ar_take && rd_sel == SEL_STATUS |=>
            rdata[BIT_REF_SEL] == $past(pll_pins.ref_b_selected, 3) && rresp == RESP_OKAY
    ) else $error("status read shows wrong selected reference");

    fb_status_a: assert property (
        $stable(mon_en) |->
            stat_byte[BIT_FB_PRESENT] == (mon_en[BIT_FB_MON_EN]
            && $past(pll_pins.fb_clk_present, 2))
    ) else $error("feedback presence flag wrong");

    ref_input_b_status_a: assert property (
        stat_byte[BIT_REF_INPUT_B_PRESENT] |->
            mon_en[BIT_REF_INPUT_B_MON_EN] && !pwr_down[BIT_REF_INPUT_B_MON_OFF]
            && $past(pll_pins.ref_b_present, 2)
    ) else $error("reference b presence flag set while invalid");

    ref_input_a_status_a: assert property (
        mon_en[BIT_REF_INPUT_A_MON_EN] && !pwr_down[BIT_REF_INPUT_A_MON_OFF]
            && $past(pll_pins.ref_a_present, 2) |-> stat_byte[BIT_REF_INPUT_A_PRESENT]
    ) else $error("reference a presence flag missing");

    lock_status_a: assert property (
        stat_byte[BIT_LOCK] == $past(pll_pins.locked, 2) && stat_byte[7:5] == 3'h0
    ) else $error("lock flag or unused status bits wrong");

    pair01_write_a: assert property (
        wr_fire && cur_lane && wr_sel == SEL_OUTPUT_DRIVER_0 |=>
            driver_ctrl.pair_pd_01 == $past(cur_byte[BIT_PAIR_PD]) && bresp == RESP_OKAY
    ) else $error("channel 0/1 power-down did not follow write");

    pair23_write_a: assert property (
        wr_fire && cur_lane && wr_sel == SEL_OUTPUT_DRIVER_2 |=>
            driver_ctrl.pair_pd_23 == $past(cur_byte[BIT_PAIR_PD])
    ) else $error("channel 2/3 power-down did not follow write");

    driver_pd_write_a: assert property (
        wr_fire && cur_lane && wr_sel == SEL_OUTPUT_DRIVER_1 |=>
            driver_ctrl.driver_pd[1] == $past(cur_byte[BIT_DRV_PD])
            && driver_ctrl.swing[1] == $past(cur_byte[BIT_SWING_LSB +: 2])
    ) else $error("output 1 driver fields did not follow write");

    swing_reset_a: assert property (
        $rose(aresetn) |-> driver_ctrl.swing == {NUM_OUT{2'b10}}
            && driver_ctrl.driver_pd == '0 && !driver_ctrl.pair_pd_01
    ) else $error("driver controls wrong after reset");

    reserved_bit_a: assert property (
        out_ctrl[1][BIT_PAIR_PD] == 1'b0
    ) else $error("reserved bit of output 1 became set");

    monitor_reset_a: assert property (
        $rose(aresetn) |-> monitor_ctrl.ref_b_mon_clk_off
            && !monitor_ctrl.ref_a_mon_clk_off && !monitor_ctrl.auto_switch_en
    ) else $error("monitor clock gates wrong after reset");

    switchover_a: assert property (
        wr_fire && cur_lane && wr_sel == SEL_PD |=>
            monitor_ctrl.auto_switch_en == !($past(cur_byte[BIT_REF_INPUT_B_MON_OFF])
            || $past(cur_byte[BIT_REF_INPUT_A_MON_OFF]))
    ) else $error("switchover enable does not match monitor gates");

    write_answer_a: assert property (
        wr_fire |=> bvalid ##0 (!awready && !wready)
    ) else $error("write not answered in one cycle");

    read_answer_a: assert property (
        ar_take |=> rvalid && !arready
    ) else $error("read not answered in one cycle");

    read_error_a: assert property (
        ar_take && rd_sel == SEL_NONE |=> rresp == RESP_SLVERR && rdata == '0
    ) else $error("unmapped read not refused");

    status_write_a: assert property (
        wr_fire && wr_sel == SEL_STATUS |=> bresp == RESP_SLVERR
    ) else $error("write to status not refused");

    output_driver_0_fields_a: assert property (
        wr_fire && cur_lane && wr_sel == SEL_OUTPUT_DRIVER_0 |=>
            driver_ctrl.driver_pd[0] == $past(cur_byte[BIT_DRV_PD])
            && driver_ctrl.swing[0] == $past(cur_byte[BIT_SWING_LSB +: 2])
    ) else $error("output 0 driver fields did not follow write");

    output_driver_2_fields_a: assert property (
        wr_fire && cur_lane && wr_sel == SEL_OUTPUT_DRIVER_2 |=>
            driver_ctrl.driver_pd[2] == $past(cur_byte[BIT_DRV_PD])
            && driver_ctrl.swing[2] == $past(cur_byte[BIT_SWING_LSB +: 2])
    ) else $error("output 2 driver fields did not follow write");

    // a write with lane 0 cleared is answered but must leave every control alone
    lane_clear_a: assert property (
        wr_fire && !cur_lane |=> $stable(driver_ctrl) && $stable(monitor_ctrl)
    ) else $error("write with lane 0 cleared changed a control");

    write_output_driver_0_c: cover property (wr_fire && cur_lane && wr_sel == SEL_OUTPUT_DRIVER_0);
    read_locked_c: cover property (ar_take && rd_sel == SEL_STATUS && stat_byte[BIT_LOCK]);
    write_error_c: cover property (wr_fire && wr_sel == SEL_STATUS);
    data_first_c: cover property (w_held && !aw_held ##1 wr_fire);
    read_error_c: cover property (ar_take && rd_sel == SEL_NONE);

endmodule : pll_status_and_output_driver_ctrl
